// ### core/rsm_pkg.sv
// Purpose: Shared constants for the receive slot mask and interrupt enable block
// Assumes: APB with 32-bit data, byte addresses in the low eight address bits
// Notes: Condition index 0..6 is overrun, sync error, clock fail, DMA error,
//        last slot, data ready, frame start
package rsm_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_SLOT_MASK = 8'h78;
    localparam logic [7:0] OFF_INT_ENABLE = 8'h7c;
    localparam logic [7:0] OFF_STATUS = 8'h80;

    // ------------------------------------------------------------
    // Reset values and field layout
    // ------------------------------------------------------------
    localparam logic [31:0] RST_SLOT_MASK = 32'h0000_0000;
    localparam logic [31:0] RST_INT_ENABLE = 32'h0000_0000;
    localparam logic [31:0] INT_ENABLE_WMASK = 32'h0000_00bf;
    localparam int NUM_COND = 7;
    localparam int COND_OVERRUN = 0;
    localparam int COND_SYNC_ERR = 1;
    localparam int COND_CLK_FAIL = 2;
    localparam int COND_DMA_ERR = 3;
    localparam int COND_LAST = 4;
    localparam int COND_DATA = 5;
    localparam int COND_FRAME = 6;
    localparam int ST_SLOT_ACTIVE = 3;
    localparam int ST_ERROR_ANY = 8;

    // ------------------------------------------------------------
    // Bit position of a condition in the enable register
    // ------------------------------------------------------------
    function automatic int en_pos(input int cond);
        case (cond)
            COND_FRAME: en_pos = 7;
            default: en_pos = cond;
        endcase
    endfunction : en_pos

    // ------------------------------------------------------------
    // Bit position of a condition in the status register
    // ------------------------------------------------------------
    function automatic int st_pos(input int cond);
        case (cond)
            COND_DMA_ERR: st_pos = 7;
            COND_FRAME: st_pos = 6;
            default: st_pos = cond;
        endcase
    endfunction : st_pos

endpackage : rsm_pkg

// ### core/rsm_flag_cell.sv
// Purpose: One sticky status flag, set by hardware, cleared by software
// Assumes: Set and clear are one-cycle pulses on clk
// Notes: A set in the clearing cycle keeps the flag high
module rsm_flag_cell (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic set_pulse,
    input wire logic clear_pulse,
    // State
    output logic flag
);

    typedef struct packed {
        logic flag;
    } rsm_cell_state_type;

    rsm_cell_state_type state_reg;
    rsm_cell_state_type state_next;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        if (set_pulse) begin
            state_next.flag = 1'b1;
        end else if (clear_pulse) begin
            state_next.flag = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign flag = state_reg.flag;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_set_wins: assert property (@(posedge clk) disable iff (rst) set_pulse |=> flag)
        else $error("flag not set after set pulse");
    a_clear_works: assert property (@(posedge clk) disable iff (rst)
        (clear_pulse && !set_pulse) |=> !flag)
        else $error("flag not cleared by write one");

endmodule : rsm_flag_cell

// ### core/rsm_top.sv
// Purpose: Receive slot mask, receive status flags and receive interrupt gate
// Assumes: APB slave, one clock, event inputs come from logic on clk
// Notes: Notes on behaviour follow
//
// Notes on behaviour
// - Slot mask bit n set makes receive slot n active; clear makes it inactive.
// - Interrupt asserts for any set condition whose enable is one; never otherwise.
// - Enable bit 7 gates frame start onto the interrupt.
// - Enable bit 5 gates data ready onto the interrupt.
// - Enable bit 4 gates last slot onto the interrupt.
// - Enable bit 3 gates DMA error onto the interrupt.
// - Enable bit 2 gates clock failure onto the interrupt.
// - Enable bit 1 gates unexpected frame sync onto the interrupt.
// - Enable bit 0 gates overrun onto the interrupt.
// - Enable bits 31 to 8 and 6 read zero; writes there do nothing.
// - Each condition sets its own flag; writing one clears it.
// - A set in the same cycle as a clear wins.
module rsm_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receive conditions
    input wire logic rx_frame_start,
    input wire logic rx_data_ready,
    input wire logic rx_final_slot,
    input wire logic rx_dma_error,
    input wire logic rx_clock_fail,
    input wire logic rx_sync_error,
    input wire logic rx_overrun,
    // Slot sequencer
    input wire logic rx_slot_strobe,
    input wire logic [4:0] rx_slot_index,
    output logic rx_slot_active,
    // Interrupt
    output logic rx_interrupt
);

    typedef struct packed {
        logic [31:0] rx_slot_mask;
        logic [31:0] rx_int_enable;
        logic slot_active;
        logic irq;
        logic ready;
        logic [31:0] rdata;
        logic slverr;
    } rsm_state_type;

    rsm_state_type state_reg;
    rsm_state_type state_next;

    logic [rsm_pkg::NUM_COND-1:0] cond_event;
    logic [rsm_pkg::NUM_COND-1:0] cond_flag;
    logic [rsm_pkg::NUM_COND-1:0] cond_clear;
    logic [rsm_pkg::NUM_COND-1:0] cond_enable;
    logic [31:0] status_value;
    logic setup_phase;
    logic access_done;
    logic irq_cause;

    // ------------------------------------------------------------
    // Condition vector and bus phases
    // ------------------------------------------------------------
    assign cond_event[rsm_pkg::COND_OVERRUN] = rx_overrun;
    assign cond_event[rsm_pkg::COND_SYNC_ERR] = rx_sync_error;
    assign cond_event[rsm_pkg::COND_CLK_FAIL] = rx_clock_fail;
    assign cond_event[rsm_pkg::COND_DMA_ERR] = rx_dma_error;
    assign cond_event[rsm_pkg::COND_LAST] = rx_final_slot;
    assign cond_event[rsm_pkg::COND_DATA] = rx_data_ready;
    assign cond_event[rsm_pkg::COND_FRAME] = rx_frame_start;

    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && state_reg.ready;

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < rsm_pkg::NUM_COND; gi++) begin : g_flag
            assign cond_clear[gi] = access_done && pwrite && (paddr == rsm_pkg::OFF_STATUS) &&
                pwdata[rsm_pkg::st_pos(gi)];
            assign cond_enable[gi] = state_reg.rx_int_enable[rsm_pkg::en_pos(gi)];
            rsm_flag_cell u_flag (
                .clk(clk),
                .rst(rst),
                .set_pulse(cond_event[gi]),
                .clear_pulse(cond_clear[gi]),
                .flag(cond_flag[gi])
            );
        end
    endgenerate

    always_comb begin
        status_value = 32'h0000_0000;
        for (int i = 0; i < rsm_pkg::NUM_COND; i++) begin
            status_value[rsm_pkg::st_pos(i)] = cond_flag[i];
        end
        status_value[rsm_pkg::ST_SLOT_ACTIVE] = state_reg.slot_active;
        status_value[rsm_pkg::ST_ERROR_ANY] = cond_flag[rsm_pkg::COND_OVERRUN] |
            cond_flag[rsm_pkg::COND_SYNC_ERR] | cond_flag[rsm_pkg::COND_CLK_FAIL] |
            cond_flag[rsm_pkg::COND_DMA_ERR];
    end

    assign irq_cause = |(cond_flag & cond_enable);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.ready = setup_phase;
        state_next.irq = irq_cause;
        if (rx_slot_strobe) begin
            state_next.slot_active = state_reg.rx_slot_mask[rx_slot_index];
        end
        if (setup_phase) begin
            state_next.slverr = 1'b0;
            state_next.rdata = 32'h0000_0000;
            case (paddr)
                rsm_pkg::OFF_SLOT_MASK: begin
                    state_next.rdata = pwrite ? 32'h0000_0000 : state_reg.rx_slot_mask;
                end
                rsm_pkg::OFF_INT_ENABLE: begin
                    state_next.rdata = pwrite ? 32'h0000_0000 :
                        (state_reg.rx_int_enable & rsm_pkg::INT_ENABLE_WMASK);
                end
                rsm_pkg::OFF_STATUS: begin
                    state_next.rdata = pwrite ? 32'h0000_0000 : status_value;
                end
                default: begin
                    state_next.slverr = 1'b1;
                end
            endcase
        end else if (!access_done) begin
            state_next.slverr = 1'b0;
        end
        if (access_done && pwrite) begin
            for (int b = 0; b < 4; b++) begin
                if (pstrb[b]) begin
                    if (paddr == rsm_pkg::OFF_SLOT_MASK) begin
                        state_next.rx_slot_mask[b*8 +: 8] = pwdata[b*8 +: 8];
                    end
                    if (paddr == rsm_pkg::OFF_INT_ENABLE) begin
                        state_next.rx_int_enable[b*8 +: 8] =
                            pwdata[b*8 +: 8] & rsm_pkg::INT_ENABLE_WMASK[b*8 +: 8];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '0;
            state_reg.rx_slot_mask <= rsm_pkg::RST_SLOT_MASK;
            state_reg.rx_int_enable <= rsm_pkg::RST_INT_ENABLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = state_reg.rdata;
    assign pready = state_reg.ready;
    assign pslverr = state_reg.slverr;
    assign rx_slot_active = state_reg.slot_active;
    assign rx_interrupt = state_reg.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_en_write;
        access_done && pwrite && (paddr == rsm_pkg::OFF_INT_ENABLE) && (pstrb == 4'hf);
    endsequence

    sequence s_en_read;
        setup_phase && !pwrite && (paddr == rsm_pkg::OFF_INT_ENABLE);
    endsequence

    a_irq_raise: assert property (irq_cause |=> rx_interrupt)
        else $error("interrupt missing for enabled flag");
    a_irq_block: assert property (!irq_cause |=> !rx_interrupt)
        else $error("interrupt without enabled flag");
    a_frame_gate: assert property ((cond_flag[6] && state_reg.rx_int_enable[7]) |=> rx_interrupt)
        else $error("frame start not gated by bit 7");
    a_data_gate: assert property ((cond_flag[5] && state_reg.rx_int_enable[5]) |=> rx_interrupt)
        else $error("data ready not gated by bit 5");
    a_last_gate: assert property ((cond_flag[4] && state_reg.rx_int_enable[4]) |=> rx_interrupt)
        else $error("last slot not gated by bit 4");
    a_dma_gate: assert property ((cond_flag[3] && state_reg.rx_int_enable[3]) |=> rx_interrupt)
        else $error("DMA error not gated by bit 3");
    a_ckfail_gate: assert property ((cond_flag[2] && state_reg.rx_int_enable[2]) |=> rx_interrupt)
        else $error("clock fail not gated by bit 2");
    a_sync_gate: assert property ((cond_flag[1] && state_reg.rx_int_enable[1]) |=> rx_interrupt)
        else $error("sync error not gated by bit 1");
    a_ovrn_gate: assert property ((cond_flag[0] && state_reg.rx_int_enable[0]) |=> rx_interrupt)
        else $error("overrun not gated by bit 0");
    a_en_write: assert property (s_en_write |=>
        state_reg.rx_int_enable == ($past(pwdata) & rsm_pkg::INT_ENABLE_WMASK))
        else $error("enable write wrong");
    a_resv_zero: assert property (s_en_read |=> (prdata[31:8] == 24'h000000) && !prdata[6])
        else $error("reserved enable bits read nonzero");
    a_slot_mask: assert property (rx_slot_strobe |=>
        rx_slot_active == $past(state_reg.rx_slot_mask[rx_slot_index]))
        else $error("slot activity does not follow mask");
    a_reset_clean: assert property (@(posedge clk) disable iff (1'b0) rst |=>
        (state_reg.rx_slot_mask == 32'h0000_0000) && !rx_interrupt && (state_reg.rx_int_enable == 32'h0000_0000))
        else $error("state not cleared by reset");
    a_set_wins_top: assert property ((cond_event[0] && cond_clear[0]) |=> cond_flag[0] ##1 rx_interrupt ||
        !state_reg.rx_int_enable[0])
        else $error("set lost against clear");

    // ------------------------------------------------------------
    // Checks on disabled conditions
    // ------------------------------------------------------------
    a_irq_quiet: assert property (!((cond_flag[6] && state_reg.rx_int_enable[7]) ||
        (cond_flag[5] && state_reg.rx_int_enable[5]) || (cond_flag[4] && state_reg.rx_int_enable[4]) ||
        (cond_flag[3] && state_reg.rx_int_enable[3]) || (cond_flag[2] && state_reg.rx_int_enable[2]) ||
        (cond_flag[1] && state_reg.rx_int_enable[1]) || (cond_flag[0] && state_reg.rx_int_enable[0])) |=>
        !rx_interrupt)
        else $error("interrupt raised by a disabled condition");
    a_frame_off: assert property (
        ((cond_flag == 7'h40) && !state_reg.rx_int_enable[7]) |=> !rx_interrupt)
        else $error("frame start passed while disabled");
    a_data_off: assert property (
        ((cond_flag == 7'h20) && !state_reg.rx_int_enable[5]) |=> !rx_interrupt)
        else $error("data ready passed while disabled");
    a_last_off: assert property (
        ((cond_flag == 7'h10) && !state_reg.rx_int_enable[4]) |=> !rx_interrupt)
        else $error("last slot passed while disabled");
    a_dma_off: assert property (
        ((cond_flag == 7'h08) && !state_reg.rx_int_enable[3]) |=> !rx_interrupt)
        else $error("DMA error passed while disabled");
    a_ckfail_off: assert property (
        ((cond_flag == 7'h04) && !state_reg.rx_int_enable[2]) |=> !rx_interrupt)
        else $error("clock fail passed while disabled");
    a_sync_off: assert property (
        ((cond_flag == 7'h02) && !state_reg.rx_int_enable[1]) |=> !rx_interrupt)
        else $error("sync error passed while disabled");
    a_overrun_off: assert property (
        ((cond_flag == 7'h01) && !state_reg.rx_int_enable[0]) |=> !rx_interrupt)
        else $error("overrun passed while disabled");

    // ------------------------------------------------------------
    // Checks on registers and reset
    // ------------------------------------------------------------
    sequence s_mask_write;
        access_done && pwrite && (paddr == rsm_pkg::OFF_SLOT_MASK) && (pstrb == 4'hf);
    endsequence

    sequence s_mask_read;
        setup_phase && !pwrite && (paddr == rsm_pkg::OFF_SLOT_MASK);
    endsequence

    sequence s_unmapped;
        setup_phase && (paddr != rsm_pkg::OFF_SLOT_MASK) && (paddr != rsm_pkg::OFF_INT_ENABLE) &&
            (paddr != rsm_pkg::OFF_STATUS);
    endsequence

    a_mask_write: assert property (
        s_mask_write |=> state_reg.rx_slot_mask == $past(pwdata))
        else $error("slot mask write wrong");
    a_mask_read: assert property (
        s_mask_read |=> prdata == $past(state_reg.rx_slot_mask))
        else $error("slot mask read wrong");
    a_mask_hold: assert property (
        !(access_done && pwrite && (paddr == rsm_pkg::OFF_SLOT_MASK)) |=> $stable(state_reg.rx_slot_mask))
        else $error("slot mask changed without a write");
    a_en_hold: assert property (
        !(access_done && pwrite && (paddr == rsm_pkg::OFF_INT_ENABLE)) |=> $stable(state_reg.rx_int_enable))
        else $error("enable changed without a write");
    a_en_resv: assert property (
        (state_reg.rx_int_enable & ~rsm_pkg::INT_ENABLE_WMASK) == 32'h0000_0000)
        else $error("reserved enable bit set");
    a_slot_hold: assert property (
        !rx_slot_strobe |=> $stable(rx_slot_active))
        else $error("slot activity changed without strobe");
    a_err_unmapped: assert property (
        s_unmapped |=> pslverr && (prdata == 32'h0000_0000))
        else $error("unmapped access not refused");
    a_reset_outputs: assert property (@(posedge clk) disable iff (1'b0)
        rst |=> !pready && !pslverr && !rx_slot_active && (prdata == 32'h0000_0000))
        else $error("outputs not cleared by reset");
    a_reset_flags: assert property (@(posedge clk) disable iff (1'b0)
        rst |=> (cond_flag == 7'h00))
        else $error("flags not cleared by reset");

endmodule : rsm_top

// ### verification/rsm_far_side.sv
// Purpose: Far-side model, source of receive events and slot strobes
// Assumes: Requests are levels set by the bench just after a clock edge
// Notes: Each rising request gives a pulse in that same cycle only
module rsm_far_side (
    // Clock
    input wire logic clk,
    // Requests from the bench
    input wire logic [6:0] ev_req,
    input wire logic slot_req,
    input wire logic [4:0] slot_num,
    // Pulses to the block
    output logic [6:0] ev_pulse,
    output logic slot_strobe,
    output logic [4:0] slot_index
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] ev_q = 7'h00;
    logic slot_q = 1'b0;
    always_ff @(posedge clk) begin
        ev_q <= ev_req;
        slot_q <= slot_req;
    end
    assign ev_pulse = ev_req & ~ev_q;
    assign slot_strobe = slot_req & ~slot_q;
    assign slot_index = slot_num;
endmodule : rsm_far_side

// ### verification/tb_top.sv
// Purpose: Self-checking bench for the receive slot mask and interrupt gate
// Assumes: APB slave that answers with pready, status word at its own offset
// Notes: Events come from the far-side model
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready, pslverr, strobe, active, irq;
    logic slot_req = 1'b0;
    logic [6:0] ev_req = 7'h00;
    logic [6:0] ev;
    logic [4:0] slot_num = 5'h00;
    logic [4:0] slot_index;
    int fails = 0;
    int compares = 0;
    int en_bit[7] = '{0, 1, 2, 3, 4, 5, 7};
    int st_bit[7] = '{0, 1, 2, 7, 4, 5, 6};
    localparam logic [31:0] MASK = 32'ha5c3_0f01;
    always #4 clk = ~clk;
    rsm_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_frame_start(ev[6]), .rx_data_ready(ev[5]), .rx_final_slot(ev[4]), .rx_dma_error(ev[3]),
        .rx_clock_fail(ev[2]), .rx_sync_error(ev[1]), .rx_overrun(ev[0]), .rx_slot_strobe(strobe),
        .rx_slot_index(slot_index), .rx_slot_active(active), .rx_interrupt(irq));
    rsm_far_side far (.clk(clk), .ev_req(ev_req), .slot_req(slot_req), .slot_num(slot_num),
        .ev_pulse(ev), .slot_strobe(strobe), .slot_index(slot_index));
    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [6:0] e,
        output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        ev_req <= e;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        ev_req <= 7'h00;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [6:0] e);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, e, rd, err);
        chk({31'h0, err}, 32'h0, "write error");
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, 7'h00, rd, err);
        chk(rd, exp, "read data");
        chk({31'h0, err}, {31'h0, experr}, "read error");
    endtask : rd_chk
    task automatic pulse(input int c);
        @(posedge clk);
        ev_req <= 7'(1 << c);
        @(posedge clk);
        ev_req <= 7'h00;
        @(posedge clk);
        @(negedge clk);
    endtask : pulse
    task automatic irq_is(input logic exp);
        repeat (2) @(negedge clk);
        chk({31'h0, irq}, {31'h0, exp}, "interrupt");
    endtask : irq_is
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    task automatic t_reset;
        rd_chk(rsm_pkg::OFF_SLOT_MASK, 32'h0, 1'b0);
        rd_chk(rsm_pkg::OFF_INT_ENABLE, 32'h0, 1'b0);
        rd_chk(rsm_pkg::OFF_STATUS, 32'h0, 1'b0);
        irq_is(1'b0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_regs;
        wr(rsm_pkg::OFF_INT_ENABLE, 32'hffff_ffff, 7'h00);
        rd_chk(rsm_pkg::OFF_INT_ENABLE, 32'h0000_00bf, 1'b0);
        wr(rsm_pkg::OFF_SLOT_MASK, MASK, 7'h00);
        rd_chk(rsm_pkg::OFF_SLOT_MASK, MASK, 1'b0);
        rd_chk(8'h84, 32'h0, 1'b1);
        $display("test registers done");
    endtask : t_regs
    task automatic t_slots;
        for (int n = 0; n < 33; n++) begin
            @(posedge clk);
            slot_req <= 1'b1;
            slot_num <= 5'((n == 32) ? 1 : n);
            @(posedge clk);
            slot_req <= 1'b0;
            @(negedge clk);
            chk({31'h0, active}, {31'h0, MASK[(n == 32) ? 1 : n]}, "slot active");
        end
        $display("test slots done");
    endtask : t_slots
    task automatic t_strobe;
        @(posedge clk);
        pstrb <= 4'h2;
        wr(rsm_pkg::OFF_SLOT_MASK, 32'h0000_0000, 7'h00);
        pstrb <= 4'he;
        wr(rsm_pkg::OFF_INT_ENABLE, 32'h0000_0000, 7'h00);
        pstrb <= 4'hf;
        rd_chk(rsm_pkg::OFF_SLOT_MASK, MASK & 32'hffff_00ff, 1'b0);
        rd_chk(rsm_pkg::OFF_INT_ENABLE, 32'h0000_00bf, 1'b0);
        $display("test byte strobes done");
    endtask : t_strobe
    task automatic t_gate;
        for (int c = 0; c < 7; c++) begin
            wr(rsm_pkg::OFF_INT_ENABLE, 32'h1 << en_bit[c], 7'h00);
            pulse(c);
            chk({31'h0, irq}, 32'h1, "enabled event");
            rd_chk(rsm_pkg::OFF_STATUS, (32'h1 << st_bit[c]) | ((c < 4) ? 32'h100 : 32'h0), 1'b0);
            wr(rsm_pkg::OFF_STATUS, 32'h1 << st_bit[c], 7'h00);
            irq_is(1'b0);
            wr(rsm_pkg::OFF_INT_ENABLE, 32'hbf & ~(32'h1 << en_bit[c]), 7'h00);
            pulse(c);
            chk({31'h0, irq}, 32'h0, "masked event");
            wr(rsm_pkg::OFF_STATUS, 32'h1 << st_bit[c], 7'h00);
        end
        $display("test gating done");
    endtask : t_gate
    task automatic t_race;
        wr(rsm_pkg::OFF_INT_ENABLE, 32'h0000_00bf, 7'h00);
        pulse(0);
        wr(rsm_pkg::OFF_STATUS, 32'h1, 7'h01);
        irq_is(1'b1);
        rd_chk(rsm_pkg::OFF_STATUS, 32'h0000_0101, 1'b0);
        wr(rsm_pkg::OFF_STATUS, 32'h1, 7'h00);
        irq_is(1'b0);
        $display("test race done");
    endtask : t_race
    task automatic t_rerun;
        pulse(0);
        irq_is(1'b1);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        $display("test mid-run reset done");
    endtask : t_rerun
    task automatic complete_run;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_regs;
        t_slots;
        t_strobe;
        t_gate;
        t_race;
        t_rerun;
        complete_run;
    end
    initial begin
        #100000;
        fails++;
        $display("[FAIL] %0t watchdog expired", $time);
        complete_run;
    end
endmodule : tb_top
